// ---- logic/trace_consts.svh ----
/*
  Shared constants of the trace port capture pair: sizes, defaults and
  the trace clock division. Assumes inclusion by its bare name.
// Function
// - Traditional mode captures continuously while core runs
// - Full capture buffer wraps, oldest overwritten
// - Traditional buffer delivered only while core halted
// - Streaming mode forwards bytes continuously to host
// - Target drives new data on both clock edges
// - Two nibbles of one clock period form byte
// - Target trace clock is half its core clock
// - Port width setting up to four, default four
// - Adjustable sample delay creates effective setup time
// - Negative delay reads data changing at edge new
// - On-chip buffer read over debug connection instead
// - No streaming when source is on-chip buffer
// - On-chip buffer is only a few kilobytes
*/
`ifndef TRACE_CONSTS_SVH
`define TRACE_CONSTS_SVH

`define TRACE_MAX_WIDTH      4
`define TRACE_WIDTH_DEFAULT  3'h4
`define TRACE_ADJ_DEFAULT    2'h0
`define TRACE_CAPTURE_DEPTH  256
`define TRACE_ONCHIP_BYTES   4096
`define TRACE_FIFO_DEPTH     4
`define TRACE_CLOCK_DIVIDE   2

`endif

// ---- logic/trace_pkg.sv ----
/*
  Types shared by the trace probe and the test bench.
  Assumes trace_consts.svh is compiled alongside.
*/
package trace_pkg;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_CAPTURE = 5'h02,
    ST_DRAIN   = 5'h04,
    ST_STREAM  = 5'h08,
    ST_ONCHIP  = 5'h10
  } probe_state_t;

  typedef logic signed [1:0] sample_adj_t;

endpackage : trace_pkg

// ---- logic/trace_link_if.sv ----
/*
  Trace port pins between the target's trace unit and the probe.
  The target drives every signal; the probe only listens.
*/
`timescale 1ns/1ps
interface trace_link_if;
  logic       trace_port_clock;
  logic [3:0] trace_data_lines;

  modport target (
    output trace_port_clock,
    output trace_data_lines
  );

  modport probe (
    input  trace_port_clock,
    input  trace_data_lines
  );
endinterface : trace_link_if

// ---- logic/trace_cdc_fifo.sv ----
/*
  Dual-clock FIFO with gray-coded pointers. DEPTH must be a power of two,
  four or more. Each side has its own synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "trace_consts.svh"
module trace_cdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `TRACE_FIFO_DEPTH
) (
  // Write side
  input  wire logic             wr_clk,
  input  wire logic             wr_rst_n,
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  wr_ready,
  // Read side
  input  wire logic             rd_clk,
  input  wire logic             rd_rst_n,
  output logic                  rd_valid,
  output logic [WIDTH-1:0]      rd_data,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_reg;
  logic [AW:0]      wgray_reg;
  logic [AW:0]      rbin_reg;
  logic [AW:0]      rgray_reg;
  logic [AW:0]      rgray_s1_reg;
  logic [AW:0]      rgray_s2_reg;
  logic [AW:0]      wgray_s1_reg;
  logic [AW:0]      wgray_s2_reg;
  logic [AW:0]      wbin_next;
  logic [AW:0]      rbin_next;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  assign wbin_next = wbin_reg + (AW+1)'(1);
  assign rbin_next = rbin_reg + (AW+1)'(1);
  // Full: top two gray bits inverted, rest equal
  assign wr_ready  = wgray_reg !=
                     {~rgray_s2_reg[AW:AW-1], rgray_s2_reg[AW-2:0]};
  assign rd_valid  = rgray_reg != wgray_s2_reg;
  assign rd_data   = mem[rbin_reg[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wbin_reg[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (!wr_rst_n) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
    end else if (wr_valid && wr_ready) begin
      wbin_reg  <= wbin_next;
      wgray_reg <= to_gray(wbin_next);
    end
  end

  always_ff @(posedge wr_clk) begin
    if (!wr_rst_n) begin
      rgray_s1_reg <= '0;
      rgray_s2_reg <= '0;
    end else begin
      rgray_s1_reg <= rgray_reg;
      rgray_s2_reg <= rgray_s1_reg;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (!rd_rst_n) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
    end else if (rd_valid && rd_ready) begin
      rbin_reg  <= rbin_next;
      rgray_reg <= to_gray(rbin_next);
    end
  end

  always_ff @(posedge rd_clk) begin
    if (!rd_rst_n) begin
      wgray_s1_reg <= '0;
      wgray_s2_reg <= '0;
    end else begin
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
    end
  end
endmodule : trace_cdc_fifo

// ---- logic/trace_source.sv ----
/*
  Target end: sends trace bytes over the trace port, four lines, DDR.
  Assumes bytes arrive on core_clk with valid/ready.
*/
`timescale 1ns/1ps
`include "trace_consts.svh"
module trace_source (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Byte source
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_valid,
  output logic            byte_ready,
  // Trace pins
  trace_link_if.target    tl
);
  logic       trace_port_clock_reg;
  logic       trace_port_clock_out_reg;
  logic       phase_reg;
  logic [3:0] hi_nib_reg;
  logic [3:0] data_reg;
  logic       ready_reg;

  assign byte_ready          = ready_reg;
  assign tl.trace_port_clock = trace_port_clock_out_reg;
  assign tl.trace_data_lines = data_reg;

  // Clock toggles every core cycle while a byte goes out
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase_reg <= 1'b0;
      trace_port_clock_reg  <= 1'b0;
      ready_reg <= 1'b1;
    end else if (phase_reg) begin
      phase_reg <= 1'b0;
      trace_port_clock_reg  <= 1'b0;
      ready_reg <= 1'b1;
    end else if (byte_valid && ready_reg) begin
      phase_reg <= 1'b1;
      trace_port_clock_reg  <= 1'b1;
      ready_reg <= 1'b0;
    end
  end

  // Low nibble with the rising edge, high nibble with the falling one
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      data_reg   <= 4'h0;
      hi_nib_reg <= 4'h0;
    end else if (phase_reg) begin
      data_reg <= hi_nib_reg;
    end else if (byte_valid && ready_reg) begin
      data_reg   <= byte_data[3:0];
      hi_nib_reg <= byte_data[7:4];
    end
  end

  // Half-cycle retime gives the probe setup time on every edge
  always_ff @(negedge core_clk) begin
    if (!nrst) begin
      trace_port_clock_out_reg <= 1'b0;
    end else begin
      trace_port_clock_out_reg <= trace_port_clock_reg;
    end
  end
endmodule : trace_source

// ---- logic/trace_probe.sv ----
/*
  Probe end: DDR trace capture on the trace port clock, crossing into
  core_clk, wrap-around capture buffer, streaming, on-chip readout.
  Assumes the target makes the trace port clock and may stop it between
  bytes; the link side only resets while that clock runs.
*/
`timescale 1ns/1ps
`include "trace_consts.svh"
module trace_probe #(
  parameter int CAP_DEPTH    = `TRACE_CAPTURE_DEPTH,
  parameter int ONCHIP_BYTES = `TRACE_ONCHIP_BYTES,
  parameter int FIFO_DEPTH   = `TRACE_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // Configuration
  input  wire logic                 stream_mode,
  input  wire logic                 source_onchip,
  input  wire logic [2:0]           trace_port_width_setting,
  input  wire trace_pkg::sample_adj_t sample_delay_adjust_command,
  input  wire logic                 target_halted,
  input  wire logic                 overflow_clear,
  // Host byte output
  output logic [7:0]                host_data,
  output logic                      host_valid,
  input  wire logic                 host_ready,
  // Debug connection reads of the on-chip buffer
  output logic                      dbg_rd_req,
  output logic [$clog2(ONCHIP_BYTES)-1:0] dbg_rd_addr,
  input  wire logic [7:0]           dbg_rd_data,
  input  wire logic                 dbg_rd_valid,
  // Status
  output logic                      stream_refused,
  output logic                      overflow,
  output logic [$clog2(CAP_DEPTH):0] capture_count,
  // Trace pins
  trace_link_if.probe               tl
);
  localparam int AW = $clog2(CAP_DEPTH);
  localparam int OW = $clog2(ONCHIP_BYTES);

  // Link domain
  logic        trace_clk_n;
  logic        lrst_s1_reg;
  logic        lrst_s2_reg;
  logic [2:0]  width_s1_reg;
  logic [2:0]  width_s2_reg;
  logic [1:0]  adj_s1_reg;
  logic [1:0]  adj_s2_reg;
  logic [3:0]  rise_nib_reg;
  logic [3:0]  prev_fall_reg;
  logic [7:0]  acc_reg;
  logic [2:0]  cnt_reg;
  logic [7:0]  acc_next;
  logic [2:0]  cnt_next;
  logic [3:0]  lo_nib;
  logic [3:0]  hi_nib;
  logic        emit;
  logic        ovf_tog_reg;
  logic        fifo_wr_ready;

  // Core domain
  logic        fifo_rd_valid;
  logic [7:0]  fifo_rd_data;
  logic        fifo_rd_ready;
  logic        halt_s1_reg;
  logic        halt_s2_reg;
  logic        ovf_s1_reg;
  logic        ovf_s2_reg;
  logic        ovf_s3_reg;
  trace_pkg::probe_state_t state_reg;
  trace_pkg::probe_state_t state_next;
  logic [7:0]  cap_mem [CAP_DEPTH];
  logic [AW-1:0] cap_wr_reg;
  logic [AW:0] cap_cnt_reg;
  logic [AW-1:0] oldest;
  logic        slot_free;
  logic        take_byte;
  logic        deliver;
  logic [7:0]  host_data_reg;
  logic        host_valid_reg;
  logic        dbg_req_reg;
  logic        dbg_wait_reg;
  logic        dbg_done_reg;
  logic [OW-1:0] dbg_addr_reg;
  logic        refused_reg;
  logic        overflow_reg;

  // Width setting: 1, 2 or 4 lines; anything else means 4
  function automatic logic [2:0] eff_width(input logic [2:0] w);
    return (w == 3'h1 || w == 3'h2) ? w : `TRACE_WIDTH_DEFAULT;
  endfunction : eff_width

  assign trace_clk_n = ~tl.trace_port_clock;

  // Link-side reset and quasi-static settings, two flops each
  always_ff @(posedge trace_clk_n) begin
    lrst_s1_reg  <= nrst;
    lrst_s2_reg  <= lrst_s1_reg;
    width_s1_reg <= trace_port_width_setting;
    width_s2_reg <= width_s1_reg;
    adj_s1_reg   <= sample_delay_adjust_command;
    adj_s2_reg   <= adj_s1_reg;
  end

  // Rising-edge nibble
  always_ff @(posedge tl.trace_port_clock) begin
    rise_nib_reg <= tl.trace_data_lines;
  end

  // Negative adjust takes each edge's value one half period later:
  // the rising slot gets what the previous falling edge saw. Positive
  // settings act as zero; finer steps need analogue delay lines.
  always_comb begin
    if (adj_s2_reg[1]) begin
      lo_nib = prev_fall_reg;
      hi_nib = rise_nib_reg;
    end else begin
      lo_nib = rise_nib_reg;
      hi_nib = tl.trace_data_lines;
    end
  end

  // Byte assembly at the falling edge, so a stopped clock loses nothing
  always_comb begin
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    emit     = 1'b0;
    case (eff_width(width_s2_reg))
      3'h1: begin
        acc_next = {hi_nib[0], lo_nib[0], acc_reg[7:2]};
        emit     = cnt_reg == 3'h6;
        cnt_next = emit ? 3'h0 : cnt_reg + 3'h2;
      end
      3'h2: begin
        acc_next = {hi_nib[1:0], lo_nib[1:0], acc_reg[7:4]};
        emit     = cnt_reg == 3'h4;
        cnt_next = emit ? 3'h0 : cnt_reg + 3'h4;
      end
      default: begin
        acc_next = {hi_nib, lo_nib};
        emit     = 1'b1;
        cnt_next = 3'h0;
      end
    endcase
  end

  always_ff @(posedge trace_clk_n) begin
    if (!lrst_s2_reg) begin
      acc_reg       <= 8'h00;
      cnt_reg       <= 3'h0;
      prev_fall_reg <= 4'h0;
      ovf_tog_reg   <= 1'b0;
    end else begin
      acc_reg       <= acc_next;
      cnt_reg       <= cnt_next;
      prev_fall_reg <= tl.trace_data_lines;
      // Target cannot be stalled: a full crossing drops the byte
      if (emit && !fifo_wr_ready) begin
        ovf_tog_reg <= ~ovf_tog_reg;
      end
    end
  end

  trace_cdc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_cdc (
    .wr_clk   (trace_clk_n),
    .wr_rst_n (lrst_s2_reg),
    .wr_valid (emit),
    .wr_data  (acc_next),
    .wr_ready (fifo_wr_ready),
    .rd_clk   (core_clk),
    .rd_rst_n (nrst),
    .rd_valid (fifo_rd_valid),
    .rd_data  (fifo_rd_data),
    .rd_ready (fifo_rd_ready)
  );

  // Core-side synchronisers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      halt_s1_reg <= 1'b0;
      halt_s2_reg <= 1'b0;
      ovf_s1_reg  <= 1'b0;
      ovf_s2_reg  <= 1'b0;
      ovf_s3_reg  <= 1'b0;
    end else begin
      halt_s1_reg <= target_halted;
      halt_s2_reg <= halt_s1_reg;
      ovf_s1_reg  <= ovf_tog_reg;
      ovf_s2_reg  <= ovf_s1_reg;
      ovf_s3_reg  <= ovf_s2_reg;
    end
  end

  always_comb begin
    if (source_onchip) begin
      state_next = halt_s2_reg ? trace_pkg::ST_ONCHIP
                               : trace_pkg::ST_IDLE;
    end else if (stream_mode) begin
      state_next = trace_pkg::ST_STREAM;
    end else if (halt_s2_reg) begin
      state_next = trace_pkg::ST_DRAIN;
    end else begin
      state_next = trace_pkg::ST_CAPTURE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= trace_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign slot_free = !host_valid_reg || host_ready;
  assign oldest    = cap_wr_reg - cap_cnt_reg[AW-1:0];

  always_comb begin
    case (state_reg)
      trace_pkg::ST_CAPTURE: fifo_rd_ready = 1'b1;
      trace_pkg::ST_STREAM:  fifo_rd_ready = slot_free;
      trace_pkg::ST_ONCHIP:  fifo_rd_ready = 1'b1;
      trace_pkg::ST_IDLE:    fifo_rd_ready = 1'b1;
      default:               fifo_rd_ready = 1'b0;
    endcase
  end

  assign take_byte = state_reg == trace_pkg::ST_CAPTURE && fifo_rd_valid;
  assign deliver   = state_reg == trace_pkg::ST_DRAIN && slot_free &&
                     cap_cnt_reg != '0;

  // Wrap-around capture buffer
  always_ff @(posedge core_clk) begin
    if (take_byte) begin
      cap_mem[cap_wr_reg] <= fifo_rd_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cap_wr_reg  <= '0;
      cap_cnt_reg <= '0;
    end else if (take_byte) begin
      cap_wr_reg <= cap_wr_reg + AW'(1);
      if (cap_cnt_reg != (AW+1)'(CAP_DEPTH)) begin
        cap_cnt_reg <= cap_cnt_reg + (AW+1)'(1);
      end
    end else if (deliver) begin
      cap_cnt_reg <= cap_cnt_reg - (AW+1)'(1);
    end
  end

  // Host output register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      host_data_reg  <= 8'h00;
      host_valid_reg <= 1'b0;
    end else if (slot_free) begin
      host_valid_reg <= 1'b0;
      case (state_reg)
        trace_pkg::ST_STREAM: begin
          if (fifo_rd_valid) begin
            host_data_reg  <= fifo_rd_data;
            host_valid_reg <= 1'b1;
          end
        end
        trace_pkg::ST_DRAIN: begin
          if (cap_cnt_reg != '0) begin
            host_data_reg  <= cap_mem[oldest];
            host_valid_reg <= 1'b1;
          end
        end
        trace_pkg::ST_ONCHIP: begin
          if (dbg_rd_valid) begin
            host_data_reg  <= dbg_rd_data;
            host_valid_reg <= 1'b1;
          end
        end
        default: host_valid_reg <= 1'b0;
      endcase
    end
  end

  // On-chip buffer walk: one read outstanding, only into a free slot
  always_ff @(posedge core_clk) begin
    if (!nrst || state_reg != trace_pkg::ST_ONCHIP) begin
      dbg_req_reg  <= 1'b0;
      dbg_wait_reg <= 1'b0;
      dbg_done_reg <= 1'b0;
      dbg_addr_reg <= '0;
    end else if (dbg_req_reg) begin
      dbg_req_reg <= 1'b0;
    end else if (dbg_wait_reg) begin
      if (dbg_rd_valid) begin
        dbg_wait_reg <= 1'b0;
        dbg_addr_reg <= dbg_addr_reg + OW'(1);
        dbg_done_reg <= dbg_addr_reg == OW'(ONCHIP_BYTES - 1);
      end
    end else if (!dbg_done_reg && !host_valid_reg) begin
      dbg_req_reg  <= 1'b1;
      dbg_wait_reg <= 1'b1;
    end
  end

  // Status flags; a new overflow wins over a clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      refused_reg  <= 1'b0;
      overflow_reg <= 1'b0;
    end else begin
      refused_reg <= stream_mode && source_onchip;
      if (ovf_s3_reg != ovf_s2_reg) begin
        overflow_reg <= 1'b1;
      end else if (overflow_clear) begin
        overflow_reg <= 1'b0;
      end
    end
  end

  assign host_data      = host_data_reg;
  assign host_valid     = host_valid_reg;
  assign dbg_rd_req     = dbg_req_reg;
  assign dbg_rd_addr    = dbg_addr_reg;
  assign stream_refused = refused_reg;
  assign overflow       = overflow_reg;
  assign capture_count  = cap_cnt_reg;
endmodule : trace_probe

// ---- test/trace_port_capture_assertions.sv ----
/* Checker of the trace link pins and of both user sides.
   Assumes the probe's core_clk and nrst; the bench instantiates it. */
`timescale 1ns/1ps
module trace_port_capture_assertions #(
  parameter int CAP_DEPTH = 8
) (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        nrst,
  // Link pins
  input wire logic                        trace_port_clock,
  input wire logic [3:0]                  trace_data_lines,
  // Source user side
  input wire logic [7:0]                  byte_data,
  input wire logic                        byte_valid,
  input wire logic                        byte_ready,
  // Probe user side
  input wire logic                        stream_mode,
  input wire logic                        source_onchip,
  input wire logic                        target_halted,
  input wire logic                        stream_refused,
  input wire logic [7:0]                  host_data,
  input wire logic                        host_valid,
  input wire logic                        host_ready,
  input wire logic [$clog2(CAP_DEPTH):0]  capture_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic take;
  assign take = byte_valid && byte_ready;

  clk_pulse_a: assert property (
    $rose(trace_port_clock) |=> !trace_port_clock)
    else $error("trace clock high over one cycle");
  low_nibble_a: assert property (
    take |=> trace_port_clock && trace_data_lines == $past(byte_data[3:0]))
    else $error("low nibble not on rising half");
  high_nibble_a: assert property (
    take |=> ##1 !trace_port_clock
      && trace_data_lines == $past(byte_data[7:4], 2))
    else $error("high nibble not on falling half");
  ready_gap_a: assert property (
    take |=> !byte_ready ##1 byte_ready)
    else $error("byte ready gap wrong");
  idle_clock_a: assert property (
    byte_ready && !byte_valid |=> !trace_port_clock)
    else $error("trace clock runs while idle");
  refuse_stream_a: assert property (
    1'b1 |=> stream_refused == ($past(stream_mode) && $past(source_onchip)))
    else $error("stream refusal wrong");
  host_hold_a: assert property (
    host_valid && !host_ready |=> host_valid && $stable(host_data))
    else $error("host byte dropped before taken");
  run_silent_a: assert property (
    (!stream_mode && !source_onchip && !target_halted) [*6] |-> !host_valid)
    else $error("host output while core runs");

  cover property (take);
  cover property (target_halted && host_valid && host_ready);
  cover property (capture_count == CAP_DEPTH);
endmodule : trace_port_capture_assertions

// ---- test/trace_port_capture_test.sv ----
/* Bench for the trace port pair: source and probe joined by the link.
   Assumes design files and checker compile first. */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module trace_port_capture_test;
  localparam int CAP = 8;
  logic       core_clk = 1'b0, nrst = 1'b0, src_nrst = 1'b0;
  logic       stream_mode = 1'b1, source_onchip = 1'b0;
  logic       target_halted = 1'b0, overflow_clear = 1'b0;
  logic       byte_valid = 1'b0, host_ready = 1'b1, rnd_ready = 1'b0;
  logic       dbg_rd_valid = 1'b0, pend = 1'b0;
  logic [7:0] byte_data = 8'h00, dbg_rd_data = 8'h00, host_data;
  logic [2:0] width = 3'h4;
  logic [1:0] dly = 2'h0;
  logic [3:0] dbg_rd_addr, addr_hold = 4'h0, capture_count;
  logic       byte_ready, host_valid, dbg_rd_req, stream_refused, overflow;
  int         mismatches = 0, num_checks = 0, reqs = 0, i;
  logic [7:0] src[$], got[$];
  logic [2:0] widths[7] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h4, 3'h4, 3'h4};
  trace_pkg::sample_adj_t adj = 2'h0;
  trace_pkg::sample_adj_t adjs[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2,
                                      2'h1};

  trace_link_if u_trace_link_if ();
  trace_source u_trace_source (.core_clk, .nrst(src_nrst), .byte_data,
    .byte_valid, .byte_ready, .tl(u_trace_link_if));
  trace_probe #(.CAP_DEPTH(CAP), .ONCHIP_BYTES(16), .FIFO_DEPTH(4))
    u_trace_probe (.core_clk, .nrst, .stream_mode, .source_onchip,
    .trace_port_width_setting(width), .sample_delay_adjust_command(adj),
    .target_halted, .overflow_clear, .host_data, .host_valid, .host_ready,
    .dbg_rd_req, .dbg_rd_addr, .dbg_rd_data, .dbg_rd_valid, .stream_refused,
    .overflow, .capture_count, .tl(u_trace_link_if));
  trace_port_capture_assertions #(.CAP_DEPTH(CAP))
    u_trace_port_capture_assertions (.core_clk, .nrst,
    .trace_port_clock(u_trace_link_if.trace_port_clock),
    .trace_data_lines(u_trace_link_if.trace_data_lines), .byte_data,
    .byte_valid, .byte_ready, .stream_mode, .source_onchip, .target_halted,
    .stream_refused, .host_data, .host_valid, .host_ready, .capture_count);

  always #25 core_clk = ~core_clk;

  // Host side collects bytes and stalls at random
  always @(posedge core_clk) begin
    if (nrst && host_valid === 1'b1 && host_ready) got.push_back(host_data);
    // Never two stalls in a row: the crossing has no more slack
    host_ready <= rnd_ready ? (!host_ready || $urandom_range(3) != 0)
                            : 1'b1;
  end

  // Debug link answers reads late; data scrambles while no read is pending
  always @(posedge core_clk) begin
    dbg_rd_valid <= 1'b0;
    if (dbg_rd_req === 1'b1) begin
      reqs++;
      pend <= 1'b1;
      dly <= 2'($urandom_range(2));
      addr_hold <= dbg_rd_addr;
    end else if (pend && dly != 2'h0) begin
      dly <= dly - 2'h1;
    end else if (pend) begin
      pend <= 1'b0;
      dbg_rd_valid <= 1'b1;
      dbg_rd_data <= onchip_byte(addr_hold);
    end else begin
      dbg_rd_data <= ~dbg_rd_data;
    end
  end

  function automatic logic [7:0] onchip_byte(input logic [3:0] a);
    return {a, ~a} ^ 8'h3C;
  endfunction : onchip_byte

  // Narrow ports pack {fall, rise} bit groups, first period lowest
  function automatic logic [7:0] expect_byte(input int k, input int eff);
    logic [7:0] r;
    logic [7:0] s;
    int         j;
    int         b;
    r = 8'h00;
    for (j = 0; j < 4 / eff; j++) begin
      s = src[k * (4 / eff) + j];
      for (b = 0; b < eff; b++) begin
        r[j * 2 * eff + b] = s[b];
        r[j * 2 * eff + eff + b] = s[4 + b];
      end
    end
    return r;
  endfunction : expect_byte

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic idle(input int n);
    byte_valid <= 1'b0;
    tick(n);
  endtask : idle

  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    byte_data <= b;
    byte_valid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (byte_ready !== 1'b1 && n < 20);
    if (byte_ready !== 1'b1) begin
      mismatches++;
      results();
    end
    src.push_back(b);
  endtask : send

  task automatic wait_got(input int n);
    int k;
    for (k = 0; k < 600 && got.size() < n; k++) tick(1);
    if (got.size() < n) begin
      mismatches++;
      results();
    end
  endtask : wait_got

  task automatic run(input int t, input int nb);
    int eff;
    int k;
    int n;
    width <= widths[t];
    adj <= adjs[t];
    idle(4);
    // Settings cross only on trace clock edges: flush them with bytes
    repeat (6) send(8'($urandom));
    idle(12);
    src.delete();
    got.delete();
    for (k = 0; k < nb; k++) begin
      send(8'($urandom));
      if ($urandom_range(1) == 1) idle(1);
    end
    idle(2);
    eff = (widths[t] == 3'h1 || widths[t] == 3'h2) ? int'(widths[t]) : 4;
    n = (adjs[t] < 0) ? nb : nb * eff / 4;
    wait_got(n);
    for (k = 0; k < n; k++)
      if (adjs[t] >= 0) `CHK(got[k], expect_byte(k, eff))
      else if (k > 0) `CHK(got[k], {src[k][3:0], src[k - 1][7:4]})
  endtask : run

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial begin
    void'($urandom(12042));
    tick(3);
    // Link side of the probe resets only while the trace clock runs
    src_nrst <= 1'b1;
    repeat (3) send(8'h00);
    idle(4);
    nrst <= 1'b1;
    repeat (3) send(8'h00);
    idle(30);
    rnd_ready <= 1'b1;
    for (i = 0; i < 7; i++) run(i, 8);
    `CHK(overflow, 1'b0)
    stream_mode <= 1'b0;
    idle(4);
    src.delete();
    got.delete();
    repeat (3) send(8'($urandom));
    idle(12);
    `CHK(capture_count, 4'h3)
    repeat (8) send(8'($urandom));
    idle(12);
    `CHK(capture_count, 4'h8)
    `CHK(got.size(), 0)
    target_halted <= 1'b1;
    wait_got(8);
    tick(4);
    for (i = 0; i < 8; i++) `CHK(got[i], src[i + 3])
    `CHK(capture_count, 4'h0)
    repeat (7) send(8'h5A);
    idle(12);
    `CHK(overflow, 1'b1)
    overflow_clear <= 1'b1;
    tick(1);
    overflow_clear <= 1'b0;
    tick(2);
    `CHK(overflow, 1'b0)
    got.delete();
    reqs = 0;
    stream_mode <= 1'b1;
    source_onchip <= 1'b1;
    tick(3);
    `CHK(stream_refused, 1'b1)
    wait_got(16);
    tick(30);
    `CHK(reqs, 16)
    for (i = 0; i < 16; i++) `CHK(got[i], onchip_byte(4'(i)))
    // Running with the on-chip source: pin trace is discarded
    target_halted <= 1'b0;
    tick(4);
    repeat (2) send(8'($urandom));
    idle(12);
    `CHK(capture_count, 4'h0)
    `CHK(got.size(), 16)
    source_onchip <= 1'b0;
    stream_mode <= 1'b0;
    tick(10);
    results();
  end
endmodule : trace_port_capture_test
